/* core/cbs_floor_ctl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cbs_map.svh"

module cbs_floor_ctl (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       defaults_load,
  input  wire logic       source_attached,
  input  wire logic       wr_floor,
  input  wire logic [7:0] wdata,
  output var  logic       force_abs,
  output var  logic [6:0] floor_code
);
  logic       attach_prev_r;
  logic       attach_rise;
  logic [6:0] wr_code;
  logic [7:0] rst_val;

  assign rst_val = `CBS_RST_FLOOR;
  assign attach_rise = source_attached & ~attach_prev_r;
  // Low codes are raised to the minimum so the floor never drops below it
  assign wr_code = (wdata[`CBS_FL_MSB:`CBS_FL_LSB] < `CBS_FLOOR_MIN) ?
                   `CBS_FLOOR_MIN : wdata[`CBS_FL_MSB:`CBS_FL_LSB];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      attach_prev_r <= 1'b0;
    end else begin
      attach_prev_r <= source_attached;
    end
  end

  // Attach and register reset outrank a host write in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst || defaults_load || attach_rise) begin
      force_abs  <= rst_val[`CBS_FA_BIT];
      floor_code <= rst_val[`CBS_FL_MSB:`CBS_FL_LSB];
    end else if (wr_floor) begin
      force_abs <= wdata[`CBS_FA_BIT];
      // Code is writable only while the absolute floor is in force
      if (force_abs) begin
        floor_code <= wr_code;
      end
    end
  end

endmodule : cbs_floor_ctl
`default_nettype wire

/* core/cbs_map.svh */
`ifndef CBS_MAP_SVH
`define CBS_MAP_SVH

// Register offsets
`define CBS_OFF_BOOST     8'h0a
`define CBS_OFF_SRC_STAT  8'h0b
`define CBS_OFF_FAULT     8'h0c
`define CBS_OFF_FLOOR     8'h0d

// Reset values of the read-write registers
`define CBS_RST_BOOST     8'h73
`define CBS_RST_FLOOR     8'h92

// Field positions in the boost register
`define CBS_BV_MSB        7
`define CBS_BV_LSB        4
`define CBS_LL_BIT        3
`define CBS_BC_MSB        2
`define CBS_BC_LSB        0

// Field positions in the floor register
`define CBS_FA_BIT        7
`define CBS_FL_MSB        6
`define CBS_FL_LSB        0
`define CBS_FLOOR_MIN     7'h0d

// Scales of the analog targets
`define CBS_BOOST_MV_BASE 13'h11c6
`define CBS_BOOST_MV_STEP 13'h0040
`define CBS_CAP_MA_BASE   12'h4b0
`define CBS_CAP_MA_STEP   12'h190
`define CBS_FLOOR_MV_BASE 14'h0a28
`define CBS_FLOOR_MV_STEP 14'h0064

`endif

/* core/cbs_pkg.sv */
package cbs_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbs_req_t;

  typedef struct packed {
    logic [2:0] source_type;
    logic [1:0] charge_phase;
    logic       power_ok;
    logic       sys_floor;
    logic       host_timeout;
    logic       boost_error;
    logic [1:0] charge_error;
    logic       battery_error;
  } cbs_live_t;

  typedef struct packed {
    logic [3:0] boost_voltage_code;
    logic       boost_light_load_disable;
    logic [2:0] boost_current_cap;
    logic       force_absolute_floor;
    logic [6:0] input_voltage_floor;
  } cbs_ctrl_t;

  typedef enum logic [1:0] {
    CBS_IDLE,
    CBS_APPLY,
    CBS_HOLD
  } cbs_rst_state_t;

endpackage : cbs_pkg

/* core/cbs_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cbs_map.svh"

module cbs_regs (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire cbs_pkg::cbs_req_t  reg_req,
  output var  logic [7:0]         rd_data_r,
  output var  logic               rd_valid_r,
  output var  logic               wr_ack_r,
  output var  logic               addr_miss_r,
  input  wire cbs_pkg::cbs_live_t live,
  input  wire logic               source_attached,
  input  wire logic               watchdog_expired,
  input  wire logic               reg_reset_cmd,
  output var  logic               reg_reset_clear_r,
  output var  logic               safety_timer_restart_r,
  output var  cbs_pkg::cbs_ctrl_t ctrl_r,
  output var  logic               pfm_allowed_r,
  output var  logic               floor_relative_r,
  output var  logic [12:0]        boost_target_mv_r,
  output var  logic [11:0]        boost_cap_ma_r,
  output var  logic [13:0]        floor_target_mv_r
);
  import cbs_pkg::*;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `CBS_OFF_BOOST)    |
             hit(a, `CBS_OFF_SRC_STAT) |
             hit(a, `CBS_OFF_FAULT)    |
             hit(a, `CBS_OFF_FLOOR);
  endfunction : mapped

  cbs_rst_state_t rst_state_r;
  cbs_rst_state_t rst_state_nxt;

  logic [7:0] boost_r;
  logic [7:0] boost_rst_val;
  logic       defaults_load;
  logic       wr_boost;
  logic       wr_floor;
  logic       force_abs;
  logic [6:0] floor_code;
  logic [7:0] src_byte;
  logic [7:0] fault_byte;
  logic [7:0] floor_byte;
  logic [7:0] rd_mux;

  assign boost_rst_val = `CBS_RST_BOOST;

  // Writes and reads are both accepted every cycle; a write is taken only
  // when the address decodes to a writable register of this slice.
  assign wr_boost = reg_req.wr & hit(reg_req.addr, `CBS_OFF_BOOST);
  assign wr_floor = reg_req.wr & hit(reg_req.addr, `CBS_OFF_FLOOR);

  // Register-reset command sequencing
  assign defaults_load = (rst_state_r == CBS_APPLY);

  always_comb begin
    rst_state_nxt = rst_state_r;
    unique case (rst_state_r)
      CBS_IDLE: begin
        if (reg_reset_cmd) begin
          rst_state_nxt = CBS_APPLY;
        end
      end
      CBS_APPLY: begin
        rst_state_nxt = CBS_HOLD;
      end
      CBS_HOLD: begin
        // Wait for the command bit to fall so one request resets once
        if (!reg_reset_cmd) begin
          rst_state_nxt = CBS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rst_state_r <= CBS_IDLE;
    end else begin
      rst_state_r <= rst_state_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_reset_clear_r      <= 1'b0;
      safety_timer_restart_r <= 1'b0;
    end else begin
      reg_reset_clear_r      <= defaults_load;
      safety_timer_restart_r <= defaults_load;
    end
  end

  // Boost register: watchdog expiry restores voltage and current cap but
  // leaves the light-load bit, which only rst or the register reset restores.
  always_ff @(posedge core_clk) begin
    if (rst || defaults_load) begin
      boost_r <= boost_rst_val;
    end else if (watchdog_expired) begin
      boost_r[`CBS_BV_MSB:`CBS_BV_LSB] <=
        boost_rst_val[`CBS_BV_MSB:`CBS_BV_LSB];
      boost_r[`CBS_BC_MSB:`CBS_BC_LSB] <=
        boost_rst_val[`CBS_BC_MSB:`CBS_BC_LSB];
    end else if (wr_boost) begin
      boost_r <= reg_req.wdata;
    end
  end

  cbs_floor_ctl u_floor (
    .core_clk        (core_clk),
    .rst             (rst),
    .defaults_load   (defaults_load),
    .source_attached (source_attached),
    .wr_floor        (wr_floor),
    .wdata           (reg_req.wdata),
    .force_abs       (force_abs),
    .floor_code      (floor_code)
  );

  cbs_status_pack u_status (
    .source_type   (live.source_type),
    .charge_phase  (live.charge_phase),
    .power_ok      (live.power_ok),
    .sys_floor     (live.sys_floor),
    .host_timeout  (live.host_timeout),
    .boost_error   (live.boost_error),
    .charge_error  (live.charge_error),
    .battery_error (live.battery_error),
    .src_byte      (src_byte),
    .fault_byte    (fault_byte)
  );

  assign floor_byte = {force_abs, floor_code};

  // Status bytes come straight from the live inputs, so nothing latches
  // or clears on a read.
  always_comb begin
    rd_mux = 8'h00;
    if (hit(reg_req.addr, `CBS_OFF_BOOST)) begin
      rd_mux = boost_r;
    end else if (hit(reg_req.addr, `CBS_OFF_SRC_STAT)) begin
      rd_mux = src_byte;
    end else if (hit(reg_req.addr, `CBS_OFF_FAULT)) begin
      rd_mux = fault_byte;
    end else if (hit(reg_req.addr, `CBS_OFF_FLOOR)) begin
      rd_mux = floor_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= reg_req.rd;
      if (reg_req.rd) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  // Writes to read-only or unmapped addresses are acknowledged but have
  // no effect; the miss flag, set for unmapped reads and writes only, lets the serial front end report those.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ack_r    <= 1'b0;
      addr_miss_r <= 1'b0;
    end else begin
      wr_ack_r    <= reg_req.wr;
      addr_miss_r <= (reg_req.wr | reg_req.rd) & ~mapped(reg_req.addr);
    end
  end

  // Control fields towards the analog loops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r           <= '0;
      pfm_allowed_r    <= 1'b0;
      floor_relative_r <= 1'b0;
    end else begin
      ctrl_r.boost_voltage_code <= boost_r[`CBS_BV_MSB:`CBS_BV_LSB];
      ctrl_r.boost_light_load_disable <= boost_r[`CBS_LL_BIT];
      ctrl_r.boost_current_cap <= boost_r[`CBS_BC_MSB:`CBS_BC_LSB];
      ctrl_r.force_absolute_floor <= force_abs;
      ctrl_r.input_voltage_floor  <= floor_code;
      pfm_allowed_r    <= ~boost_r[`CBS_LL_BIT];
      floor_relative_r <= ~force_abs;
    end
  end

  // Targets in mV and mA; products fit the sized widths at full code
  always_ff @(posedge core_clk) begin
    if (rst) begin
      boost_target_mv_r <= '0;
      boost_cap_ma_r    <= '0;
      floor_target_mv_r <= '0;
    end else begin
      boost_target_mv_r <= `CBS_BOOST_MV_BASE + 13'(`CBS_BOOST_MV_STEP *
        {9'h000, boost_r[`CBS_BV_MSB:`CBS_BV_LSB]});
      boost_cap_ma_r <= `CBS_CAP_MA_BASE + 12'(`CBS_CAP_MA_STEP *
        {9'h000, boost_r[`CBS_BC_MSB:`CBS_BC_LSB]});
      // Relative mode leaves this value unused by the loop
      floor_target_mv_r <= `CBS_FLOOR_MV_BASE + 14'(`CBS_FLOOR_MV_STEP *
        {7'h00, floor_code});
    end
  end

endmodule : cbs_regs
`default_nettype wire

/* core/cbs_status_pack.sv */
`timescale 1ns/1ns
`default_nettype none

module cbs_status_pack (
  input  wire logic [2:0] source_type,
  input  wire logic [1:0] charge_phase,
  input  wire logic       power_ok,
  input  wire logic       sys_floor,
  input  wire logic       host_timeout,
  input  wire logic       boost_error,
  input  wire logic [1:0] charge_error,
  input  wire logic       battery_error,
  output var  logic [7:0] src_byte,
  output var  logic [7:0] fault_byte
);
  // Current cap is not folded in here; it lives in its own field
  assign src_byte = {source_type,
                     charge_phase,
                     power_ok,
                     1'b0,
                     sys_floor};
  assign fault_byte = {host_timeout,
                       boost_error,
                       charge_error,
                       battery_error,
                       3'h0};

endmodule : cbs_status_pack
`default_nettype wire

/* dv/cbs_host.sv */
`timescale 1ns/1ns
`default_nettype none

module cbs_host (
  input  wire logic              core_clk,
  input  wire logic              rd_valid_r,
  input  wire logic [7:0]        rd_data_r,
  input  wire logic              reg_reset_clear_r,
  output var  cbs_pkg::cbs_req_t reg_req,
  output var  logic              reg_reset_cmd
);
  import cbs_pkg::*;
  initial begin
    reg_req = '0;
    reg_reset_cmd = 1'b0;
  end
  // Command bit is owned here and dropped once the device reports done
  always @(posedge core_clk) begin
    if (reg_reset_clear_r) reg_reset_cmd <= 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge core_clk);
    reg_req <= '{1'b1, 1'b0, a, dt};
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b0, ~a, ~dt};
  endtask : wr
  // Read data is taken in the answer cycle only; otherwise unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] dt);
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h5a};
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b0, ~a, 8'ha5};
    #1 dt = rd_valid_r ? rd_data_r : 8'hxx;
  endtask : rd
  task automatic reg_reset();
    @(posedge core_clk);
    reg_reset_cmd <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : reg_reset
endmodule : cbs_host
`default_nettype wire

/* dv/cbs_regs_sva.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cbs_map.svh"

module cbs_regs_chk (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire cbs_pkg::cbs_req_t  reg_req,
  input wire logic [7:0]         rd_data_r,
  input wire logic               rd_valid_r,
  input wire logic               addr_miss_r,
  input wire logic               wr_ack_r,
  input wire cbs_pkg::cbs_live_t live,
  input wire logic               reg_reset_cmd,
  input wire logic               reg_reset_clear_r,
  input wire logic               safety_timer_restart_r,
  input wire cbs_pkg::cbs_ctrl_t ctrl_r,
  input wire logic [12:0]        boost_target_mv_r,
  input wire logic [11:0]        boost_cap_ma_r,
  input wire logic [13:0]        floor_target_mv_r
);
  import cbs_pkg::*;
  logic [1:0] rst_q;
  logic       settled;
  // Outputs lag reset release by two edges, so mapping checks wait
  always_ff @(posedge core_clk) begin
    rst_q <= {rst_q[0], rst};
  end
  assign settled = (rst_q == 2'b00);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (reg_req.rd |=> rd_valid_r)
    else $error("read gave no valid pulse");
  a_write_ack: assert property (reg_req.wr |=> wr_ack_r)
    else $error("write gave no acknowledge");
  a_addr_miss: assert property (
    (reg_req.rd || reg_req.wr) && !(reg_req.addr inside {[8'h0a:8'h0d]})
    |=> addr_miss_r) else $error("unmapped access not flagged");
  a_src_read: assert property (
    reg_req.rd && reg_req.addr == `CBS_OFF_SRC_STAT |=> rd_data_r ==
    {$past(live.source_type), $past(live.charge_phase),
     $past(live.power_ok), 1'b0, $past(live.sys_floor)})
    else $error("status byte wrong");
  a_boost_mv: assert property (settled |-> boost_target_mv_r ==
    `CBS_BOOST_MV_BASE + `CBS_BOOST_MV_STEP * ctrl_r.boost_voltage_code)
    else $error("boost target wrong");
  a_cap_ma: assert property (settled |-> boost_cap_ma_r ==
    `CBS_CAP_MA_BASE + `CBS_CAP_MA_STEP * ctrl_r.boost_current_cap)
    else $error("boost cap wrong");
  a_floor_mv: assert property (settled |-> floor_target_mv_r ==
    `CBS_FLOOR_MV_BASE + `CBS_FLOOR_MV_STEP * ctrl_r.input_voltage_floor)
    else $error("floor target wrong");
  a_floor_clamp: assert property (
    settled |-> ctrl_r.input_voltage_floor >= `CBS_FLOOR_MIN)
    else $error("floor code under minimum");
  a_reset_start: assert property (
    $rose(reg_reset_cmd) |-> ##2 reg_reset_clear_r)
    else $error("register reset not completed");
  a_reset_done: assert property (
    reg_reset_clear_r |-> safety_timer_restart_r && $past(reg_reset_cmd, 2))
    else $error("reset completion without command");
  c_src_read: cover property (reg_req.rd && reg_req.addr == 8'h0b);
  c_reset: cover property (reg_reset_clear_r);
  c_miss: cover property (addr_miss_r);
endmodule : cbs_regs_chk
`default_nettype wire

/* dv/test_charger_boost_status_regs.sv */
`timescale 1ns/1ns
`default_nettype none

module test_charger_boost_status_regs;
  import cbs_pkg::*;
  logic        core_clk, rst, source_attached, watchdog_expired;
  logic        reg_reset_cmd, rd_valid_r, reg_reset_clear_r;
  logic        pfm_allowed_r, floor_relative_r;
  logic [7:0]  rd_data_r, d, v;
  logic [12:0] boost_target_mv_r;
  logic [11:0] boost_cap_ma_r;
  logic [13:0] floor_target_mv_r;
  logic [2:0]  st [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  cbs_req_t    reg_req;
  cbs_live_t   live, lv;
  int          failures = 0;
  int          checks = 0;

  cbs_regs dut_u (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .wr_ack_r(),
    .addr_miss_r(), .live(live), .source_attached(source_attached),
    .watchdog_expired(watchdog_expired), .reg_reset_cmd(reg_reset_cmd),
    .reg_reset_clear_r(reg_reset_clear_r), .safety_timer_restart_r(),
    .ctrl_r(), .pfm_allowed_r(pfm_allowed_r),
    .floor_relative_r(floor_relative_r),
    .boost_target_mv_r(boost_target_mv_r),
    .boost_cap_ma_r(boost_cap_ma_r), .floor_target_mv_r(floor_target_mv_r));
  cbs_host host_u (.core_clk(core_clk), .rd_valid_r(rd_valid_r),
    .rd_data_r(rd_data_r), .reg_reset_clear_r(reg_reset_clear_r),
    .reg_req(reg_req), .reg_reset_cmd(reg_reset_cmd));

  function automatic int exp_src(cbs_live_t l);
    return {l.source_type, l.charge_phase, l.power_ok, 1'b0, l.sys_floor};
  endfunction : exp_src
  function automatic int exp_flt(cbs_live_t l);
    return {l.host_timeout, l.boost_error, l.charge_error,
            l.battery_error, 3'b000};
  endfunction : exp_flt
  task automatic chk(input string n, input int e, input logic [15:0] g);
    checks++;
    if (g !== 16'(e)) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    rst = 1'b1;
    live = '0;
    source_attached = 1'b0;
    watchdog_expired = 1'b0;
    void'($urandom(91));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    host_u.rd(8'h0a, d);
    chk("boost reset", 8'h73, d);
    host_u.rd(8'h0d, d);
    chk("floor reset", 8'h92, d);
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], 4'($urandom)};
      host_u.wr(8'h0a, v);
      repeat (2) @(posedge core_clk);
      #1 chk("boost mv", 4550 + 64 * i, boost_target_mv_r);
      chk("cap ma", 1200 + 400 * v[2:0], boost_cap_ma_r);
      chk("pfm", !v[3], pfm_allowed_r);
      host_u.rd(8'h0a, d);
      chk("boost rb", v, d);
    end
    $display("boost codes done");
    for (int i = 0; i < 8; i++) begin
      lv = cbs_live_t'(12'($urandom));
      lv.source_type = st[i % 4];
      lv.charge_phase = i[1:0];
      @(posedge core_clk);
      live <= lv;
      host_u.wr(8'h0b, 8'hff);
      host_u.rd(8'h0b, d);
      chk("src stat", exp_src(lv), d);
      host_u.rd(8'h0c, d);
      chk("fault", exp_flt(lv), d);
    end
    host_u.wr(8'h20, 8'h00);
    host_u.rd(8'h20, d);
    chk("unmapped", 0, d);
    $display("status done");
    host_u.wr(8'h0d, 8'h85);
    host_u.rd(8'h0d, d);
    chk("clamp", 8'h8d, d);
    host_u.wr(8'h0d, 8'h7f);
    host_u.rd(8'h0d, d);
    chk("floor wr", 8'h7f, d);
    chk("floor mv", 2600 + 100 * 127, floor_target_mv_r);
    chk("relative", 1, floor_relative_r);
    host_u.wr(8'h0d, 8'h85);
    host_u.rd(8'h0d, d);
    chk("floor ro", 8'hff, d);
    @(posedge core_clk);
    source_attached <= 1'b1;
    host_u.rd(8'h0d, d);
    chk("attach", 8'h92, d);
    $display("floor done");
    host_u.wr(8'h0a, 8'h48);
    host_u.wr(8'h0d, 8'h20);
    host_u.reg_reset();
    chk("cmd clear", 0, reg_reset_cmd);
    host_u.rd(8'h0a, d);
    chk("rst boost", 8'h73, d);
    host_u.rd(8'h0d, d);
    chk("rst floor", 8'h92, d);
    host_u.wr(8'h0a, 8'hf8);
    @(posedge core_clk);
    watchdog_expired <= 1'b1;
    @(posedge core_clk);
    watchdog_expired <= 1'b0;
    host_u.rd(8'h0a, d);
    chk("watchdog", 8'h7b, d);
    $display("register reset done");
    results();
  end
endmodule : test_charger_boost_status_regs

bind cbs_regs cbs_regs_chk chk_u (.core_clk(core_clk), .rst(rst),
  .reg_req(reg_req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
  .addr_miss_r(addr_miss_r), .wr_ack_r(wr_ack_r),
  .live(live), .reg_reset_cmd(reg_reset_cmd),
  .reg_reset_clear_r(reg_reset_clear_r), .ctrl_r(ctrl_r),
  .safety_timer_restart_r(safety_timer_restart_r),
  .boost_target_mv_r(boost_target_mv_r), .boost_cap_ma_r(boost_cap_ma_r),
  .floor_target_mv_r(floor_target_mv_r));
`default_nettype wire
